// *** shared/timer8_pkg.sv ***
`default_nettype none
package timer8_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ctrl_off    = 8'h00;
  localparam logic [7:0] counter_off = 8'h04;
  localparam logic [7:0] compare_off = 8'h08;
  localparam logic [7:0] status_off  = 8'h0c;
  localparam logic [7:0] port_off    = 8'h10;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int wmode_lsb   = 0;
  localparam int com_lsb     = 2;
  localparam int run_bit     = 4;
  localparam int force_bit   = 5;
  localparam int ovf_bit     = 0;
  localparam int cmpf_bit    = 1;
  localparam int port_val_bit = 0;
  localparam int port_dir_bit = 1;
  localparam int ocs_bit      = 2;
  localparam int pin_lvl_bit  = 3;

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [7:0] cnt_max     = 8'hff;
  localparam logic [7:0] cnt_bottom  = 8'h00;
  localparam logic [7:0] cnt_rst     = 8'h00;
  localparam logic [7:0] cmp_rst     = 8'h00;
  localparam logic [1:0] com_none    = 2'h0;
  localparam logic [1:0] com_toggle  = 2'h1;
  localparam logic [1:0] com_clear   = 2'h2;
  localparam logic [1:0] com_set     = 2'h3;

  typedef enum logic [1:0] {
    wm_normal    = 2'h0,
    wm_phase_pwm = 2'h1,
    wm_clear_on_match = 2'h2,
    wm_fast_pwm  = 2'h3
  } waveform_mode_t;

  typedef struct packed {
    logic           run;
    logic [1:0]     compare_output_mode;
    waveform_mode_t waveform_mode;
  } ctrl_t;

  localparam ctrl_t ctrl_rst = '{run: 1'b0, compare_output_mode: 2'h0,
                                 waveform_mode: wm_normal};

endpackage
`default_nettype wire

// *** src/timer8_waveform_output.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1 - nonzero output mode drives pin from state
// RL2 - direction bit alone governs pin enable
// RL3 - override ignores waveform mode
// RL4 - output state writable, kept apart from pin
// RL5 - output mode zero leaves state unchanged
// RL6 - new output mode acts next match; force immediate
// RL7 - only waveform mode steers counting
// RL8 - normal mode counts up, wraps ff to 00
// RL9 - normal overflow flag set when counter zeroes
// RL10 - counter writable any time in normal mode
// RL11 - clear-on-match: compare is top, then zero
// RL12 - compare below count missed, wraps first
// RL13 - clear-on-match raises compare flag each period
// RL14 - clear-on-match output mode one toggles state
// RL15 - clear-on-match overflow on max to zero
// RL16 - fast pwm counts zero to max, restarts
// RL17 - fast pwm clears after max next tick
// RL18 - fast pwm: two clear/set, three inverse
// RL19 - fast pwm overflow flag at max
// RL20 - fast pwm extremes: spike, constant level
// RL21 - compare buffered in pwm, direct otherwise
// RL22 - match sets flag next tick; one clears
// RL23 - force acts as match, no flag, no clear
// RL24 - reset: modes zero, pin under port
module timer8_waveform_output #(
  parameter int TICK_DIV = 1
) (
  input  wire logic        mclk,      // 10 MHz system clock
  input  wire logic        reset,     // async, active high
  input  wire logic        wb_cyc_i,  // wishbone cycle
  input  wire logic        wb_stb_i,  // wishbone strobe
  input  wire logic        wb_we_i,   // wishbone write
  input  wire logic [7:0]  wb_adr_i,  // byte address
  input  wire logic [3:0]  wb_sel_i,  // byte lanes
  input  wire logic [31:0] wb_dat_i,  // write data
  output logic      [31:0] wb_dat_o,  // read data
  output logic             wb_ack_o,  // acknowledge
  output logic             pin_out,   // pin output level
  output logic             pin_oe     // pin drive enable
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  // the divider counts in 16 bits: one tick per 65536 cycles at most
  if (TICK_DIV < 1 || TICK_DIV > 65536) begin : g_tick_div_bad
    $error("TICK_DIV out of range");
  end

  // writes honour byte lane 0 only, so every field must sit there
  if (timer8_pkg::force_bit > 7 || timer8_pkg::pin_lvl_bit > 7) begin : g_field_bad
    $error("register field outside byte lane 0");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  timer8_pkg::ctrl_t ctrl_r;
  logic [7:0]  counter_value_r;
  logic [7:0]  compare_buf_r;
  logic [7:0]  compare_value_r;
  logic        overflow_flag_r;
  logic        compare_flag_r;
  logic        compare_output_state_r;
  logic        port_val_r;
  logic        output_pin_direction_bit_r;
  logic        block_r;
  logic        timer_tick_r;
  logic [15:0] div_r;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic req;
  logic wr;
  logic wr_lane0;
  logic wr_ctrl;
  logic wr_counter;
  logic wr_compare;
  logic wr_status;
  logic wr_port;
  logic force_strobe;
  logic force_compare_strobe;
  logic force_nonpwm;
  logic [1:0] force_com;

  assign req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr         = req & wb_we_i;
  assign wr_lane0   = wr & wb_sel_i[0];
  assign wr_ctrl    = wr_lane0 & (wb_adr_i == timer8_pkg::ctrl_off);
  assign wr_counter = wr_lane0 & (wb_adr_i == timer8_pkg::counter_off);
  assign wr_compare = wr_lane0 & (wb_adr_i == timer8_pkg::compare_off);
  assign wr_status  = wr_lane0 & (wb_adr_i == timer8_pkg::status_off);
  assign wr_port    = wr_lane0 & (wb_adr_i == timer8_pkg::port_off);
  assign force_strobe = wr_ctrl & wb_dat_i[timer8_pkg::force_bit];
  // a strobe acts under the modes written along with it
  assign force_nonpwm = ~wb_dat_i[timer8_pkg::wmode_lsb];
  assign force_com    = wb_dat_i[timer8_pkg::com_lsb +: 2]; // RL6

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  logic is_pwm;
  logic is_ctc;
  logic is_fast;
  logic at_max;
  logic match;
  logic tick_match;
  logic wrap_tick;

  assign is_ctc  = ctrl_r.waveform_mode == timer8_pkg::wm_clear_on_match;
  assign is_fast = ctrl_r.waveform_mode == timer8_pkg::wm_fast_pwm;
  // phase-correct mode only counts up here, but keeps its buffering
  assign is_pwm  = ctrl_r.waveform_mode[0];
  assign at_max  = counter_value_r == timer8_pkg::cnt_max;
  // equality only: a top written below the count is passed over
  assign match      = counter_value_r == compare_value_r; // RL12
  assign tick_match = timer_tick_r & match & ~block_r;
  assign wrap_tick  = timer_tick_r & at_max;
  // force only in non-pwm modes
  assign force_compare_strobe = force_strobe & force_nonpwm; // RL23

  // ---------------------------------------------------------------
  // tick divider
  // ---------------------------------------------------------------
  logic div_last;
  // the tick is registered, so it follows this count by a cycle
  assign div_last = div_r == 16'(TICK_DIV - 1);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_r        <= 16'h0000;
      timer_tick_r <= 1'b0;
    end else if (!ctrl_r.run) begin
      div_r        <= 16'h0000;
      timer_tick_r <= 1'b0;
    end else if (div_last) begin
      div_r        <= 16'h0000;
      timer_tick_r <= 1'b1;
    end else begin
      div_r        <= div_r + 16'h0001;
      timer_tick_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_r <= timer8_pkg::ctrl_rst; // RL24
    end else if (wr_ctrl) begin
      ctrl_r.waveform_mode <= timer8_pkg::waveform_mode_t'(
        wb_dat_i[timer8_pkg::wmode_lsb +: 2]);
      // takes hold at once; acts on the next match
      ctrl_r.compare_output_mode <= wb_dat_i[timer8_pkg::com_lsb +: 2]; // RL6
      // the force bit is a strobe and is never stored
      ctrl_r.run <= wb_dat_i[timer8_pkg::run_bit];
    end
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      counter_value_r <= timer8_pkg::cnt_rst;
    end else if (wr_counter) begin
      // cpu write beats any count or clear
      counter_value_r <= wb_dat_i[7:0]; // RL10
    end else if (timer_tick_r) begin
      // output mode plays no part here
      if (is_ctc && match) begin // RL7
        counter_value_r <= timer8_pkg::cnt_bottom; // RL11
      end else begin
        // wraps ff to 00 in normal and fast pwm
        counter_value_r <= counter_value_r + 8'h01; // RL8 RL16 RL17
      end
    end
  end

  // ---------------------------------------------------------------
  // match blocking
  // ---------------------------------------------------------------
  // a counter write blocks the match of the next tick, even when stopped
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      block_r <= 1'b0;
    end else if (wr_counter) begin
      block_r <= 1'b1;
    end else if (timer_tick_r) begin
      block_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // compare value, buffered in pwm modes
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      compare_buf_r <= timer8_pkg::cmp_rst;
    end else if (wr_compare) begin
      // software always reads back this buffer
      compare_buf_r <= wb_dat_i[7:0];
    end
  end

  // ---------------------------------------------------------------
  // active compare value
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      compare_value_r <= timer8_pkg::cmp_rst;
    end else if (!is_pwm) begin
      compare_value_r <= wr_compare ? wb_dat_i[7:0] : compare_buf_r; // RL21
    end else if (wrap_tick) begin
      compare_value_r <= compare_buf_r; // RL21
    end
  end

  // ---------------------------------------------------------------
  // overflow flag: set wins over write-one clear
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      overflow_flag_r <= 1'b0;
    end else if (wrap_tick) begin
      // counter leaves max and becomes zero
      overflow_flag_r <= 1'b1; // RL9 RL15 RL19
    end else if (wr_status && wb_dat_i[timer8_pkg::ovf_bit]) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // compare flag: set wins over write-one clear
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      compare_flag_r <= 1'b0;
    end else if (tick_match) begin
      // once per period at top in clear-on-match
      compare_flag_r <= 1'b1; // RL22 RL13
    end else if (wr_status && wb_dat_i[timer8_pkg::cmpf_bit]) begin
      compare_flag_r <= 1'b0; // RL22
    end
  end

  // ---------------------------------------------------------------
  // waveform generator
  // ---------------------------------------------------------------
  logic [1:0] com;
  logic [1:0] act_com;
  logic       act_en;
  logic       bottom_en;

  assign com       = ctrl_r.compare_output_mode;
  // a forced match takes the output mode of its own write
  assign act_com   = force_compare_strobe ? force_com : com; // RL6
  assign act_en    = tick_match | force_compare_strobe; // RL23
  // only the set and clear output modes act at bottom
  assign bottom_en = is_fast & wrap_tick & com[1]; // RL18

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      compare_output_state_r <= 1'b0;
    end else if (wr_port) begin
      // preset before the pin is made an output
      compare_output_state_r <= wb_dat_i[timer8_pkg::ocs_bit]; // RL4
    end else if (bottom_en) begin
      // bottom beats a match at max: constant level for top = max
      compare_output_state_r <= ~com[0]; // RL18 RL20
    end else if (act_en) begin // RL23
      unique case (act_com)
        timer8_pkg::com_none:   compare_output_state_r <= compare_output_state_r; // RL5
        timer8_pkg::com_toggle: compare_output_state_r <= ~compare_output_state_r; // RL14
        timer8_pkg::com_clear:  compare_output_state_r <= 1'b0; // RL18
        timer8_pkg::com_set:    compare_output_state_r <= 1'b1; // RL18
      endcase
    end
  end

  // ---------------------------------------------------------------
  // port pin
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      port_val_r                 <= 1'b0;
      output_pin_direction_bit_r <= 1'b0;
    end else if (wr_port) begin
      port_val_r                 <= wb_dat_i[timer8_pkg::port_val_bit];
      output_pin_direction_bit_r <= wb_dat_i[timer8_pkg::port_dir_bit];
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  logic pin_src;
  // override depends on output mode only, never on the waveform mode
  assign pin_src = (com != timer8_pkg::com_none) ? // RL1 RL3
                   compare_output_state_r :
                   port_val_r;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_out <= 1'b0;
    end else begin
      pin_out <= pin_src;
    end
  end

  // direction stays with the port bit even under override
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_oe <= 1'b0;
    end else begin
      pin_oe <= output_pin_direction_bit_r; // RL2
    end
  end

  // ---------------------------------------------------------------
  // register read mux: unmapped offsets read zero
  // ---------------------------------------------------------------
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      timer8_pkg::ctrl_off: begin
        rdata[timer8_pkg::wmode_lsb +: 2] = ctrl_r.waveform_mode;
        rdata[timer8_pkg::com_lsb +: 2]   = ctrl_r.compare_output_mode;
        rdata[timer8_pkg::run_bit]        = ctrl_r.run;
      end
      timer8_pkg::counter_off: rdata[7:0] = counter_value_r;
      timer8_pkg::compare_off: rdata[7:0] = compare_buf_r;
      timer8_pkg::status_off: begin
        rdata[timer8_pkg::ovf_bit]  = overflow_flag_r;
        rdata[timer8_pkg::cmpf_bit] = compare_flag_r;
      end
      timer8_pkg::port_off: begin
        rdata[timer8_pkg::port_val_bit] = port_val_r;
        rdata[timer8_pkg::port_dir_bit] = output_pin_direction_bit_r;
        rdata[timer8_pkg::ocs_bit]      = compare_output_state_r;
        rdata[timer8_pkg::pin_lvl_bit]  = pin_out;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // wishbone answer: one wait state
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      // ~ack in req keeps a held request from being taken twice
      wb_ack_o <= req;
    end
  end

  // data reads zero outside an answer
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= req ? rdata : 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// *** tb/pin_load.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  input  wire logic pin_out,  // driven level
  input  wire logic pin_oe,   // drive enable
  output logic      level     // wire level
);
  // released pin falls to the load's pull-down
  assign level = pin_oe ? pin_out : 1'b0;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk, reset, cyc, stb, we, ack, pout, poe, lvl;
  logic [7:0]  adr, v, s0;
  logic [3:0]  sel;
  logic [31:0] dat, rdat;
  int          error_cnt, compares, cyc_n;
  timer8_waveform_output #(.TICK_DIV(1)) timer8_waveform_output_inst (
    .mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pin_out(pout), .pin_oe(poe));
  pin_load pin_load_inst (.pin_out(pout), .pin_oe(poe), .level(lvl));
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // bus and compare
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'h1;
    do @(posedge mclk); while (ack !== 1'b1);
    v = rdat[7:0];
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t %s", $time, m);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string m);
    bus(1'b0, a, 32'h0);
    chk(v, exp, m);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask
  function automatic logic [7:0] cv(input logic [1:0] wm, c, input logic r, f);
    return {2'h0, f, r, c, wm};
  endfunction
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    foreach (offs[i]) rdc(offs[i], 8'h00, "reset value");
    $display("reset test done");
  endtask
  task automatic t_normal;
    wr(8'h04, 8'hfd);
    wr(8'h0c, 8'h03);
    wr(8'h00, cv(2'h0, 2'h0, 1'b1, 1'b0));
    w(10);
    wr(8'h00, 8'h00);
    rdc(8'h0c, 8'h03, "normal overflow");
    bus(1'b0, 8'h04, 32'h0);
    chk({7'h0, v < 8'h20}, 8'h01, "normal wrap");
    $display("normal test done");
  endtask
  task automatic t_ctc;
    int n;
    logic p;
    wr(8'h08, 8'h03);
    wr(8'h04, 8'h00);
    wr(8'h0c, 8'h03);
    wr(8'h10, 8'h02);
    wr(8'h00, cv(2'h2, 2'h1, 1'b1, 1'b0));
    n = 0;
    p = lvl;
    repeat (40) begin
      @(posedge mclk);
      if (lvl !== p) n++;
      p = lvl;
    end
    wr(8'h00, 8'h00);
    chk({7'h0, n >= 8 && n <= 11}, 8'h01, "ctc toggles");
    bus(1'b0, 8'h04, 32'h0);
    chk({7'h0, v <= 8'h03}, 8'h01, "ctc top");
    rdc(8'h0c, 8'h02, "ctc flags");
    $display("ctc test done");
  endtask
  task automatic t_miss;
    wr(8'h04, 8'h40);
    wr(8'h0c, 8'h03);
    bus(1'b0, 8'h10, 32'h0);
    s0 = v;
    wr(8'h00, cv(2'h2, 2'h0, 1'b1, 1'b0));
    w(100);
    wr(8'h00, 8'h00);
    bus(1'b0, 8'h04, 32'h0);
    chk({7'h0, v > 8'h40}, 8'h01, "missed top");
    rdc(8'h0c, 8'h00, "no match");
    rdc(8'h10, s0 & 8'h07, "state held");
    $display("miss test done");
  endtask
  task automatic t_pwm;
    int bad;
    for (int c = 2; c <= 3; c++) begin
      wr(8'h08, 8'hff);
      wr(8'h04, 8'h00);
      wr(8'h0c, 8'h03);
      wr(8'h00, cv(2'h3, c[1:0], 1'b1, 1'b0));
      w(300);
      bad = 0;
      repeat (300) begin
        @(posedge mclk);
        if (lvl !== (c == 2)) bad++;
      end
      chk({7'h0, bad == 0}, 8'h01, "pwm level");
      wr(8'h00, 8'h00);
      rdc(8'h0c, 8'h03, "pwm overflow");
    end
    $display("pwm test done");
  endtask
  task automatic t_force;
    wr(8'h0c, 8'h03);
    wr(8'h04, 8'h20);
    // set, clear, toggle, then no action: state 1, 0, 1, 1
    for (int c = 3; c >= 0; c--) begin
      wr(8'h00, cv(2'h0, c[1:0], 1'b0, 1'b1));
      rdc(8'h10, {4'h0, c[0], c != 2, 2'h2}, "forced state");
      rdc(8'h0c, 8'h00, "force flag");
      rdc(8'h04, 8'h20, "force count");
      rdc(8'h00, {4'h0, c[1:0], 2'h0}, "ctrl read");
    end
    $display("force test done");
  endtask
  // a hang in a bus wait ends here
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    reset = 1; cyc = 0; stb = 0; we = 0; adr = 8'h0; sel = 4'h0; dat = 32'h0;
    error_cnt = 0; compares = 0; cyc_n = 0;
    repeat (8) @(posedge mclk);
    reset <= 0;
    t_reset();
    t_normal();
    t_ctc();
    t_miss();
    t_pwm();
    t_force();
    end_sim();
  end
endmodule
`default_nettype wire

// *** tb/timer8_wave_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer8_wave_chk #(
  parameter int TICK_DIV = 1
) (
  input wire logic        mclk,      // clock
  input wire logic        reset,     // reset
  input wire logic        wb_cyc_i,  // cycle
  input wire logic        wb_stb_i,  // strobe
  input wire logic        wb_we_i,   // write
  input wire logic [7:0]  wb_adr_i,  // address
  input wire logic [3:0]  wb_sel_i,  // lanes
  input wire logic [31:0] wb_dat_i,  // write data
  input wire logic [31:0] wb_dat_o,  // read data
  input wire logic        wb_ack_o,  // ack
  input wire logic        pin_out,   // pin level
  input wire logic        pin_oe     // pin enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [1:0] com_r;
  logic       pv_r;
  logic       dir_r;
  logic       tk;
  assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // shadows of the software-only fields; hardware never alters them
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      com_r <= 2'h0;
      pv_r  <= 1'b0;
      dir_r <= 1'b0;
    end else if (tk & wb_we_i & wb_sel_i[0]) begin
      if (wb_adr_i == timer8_pkg::ctrl_off) com_r <= wb_dat_i[3:2];
      if (wb_adr_i == timer8_pkg::port_off) begin
        pv_r  <= wb_dat_i[0];
        dir_r <= wb_dat_i[1];
      end
    end
  end
  property p_ack_lat; tk |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack stuck");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
  property p_unmapped; tk && !wb_we_i && wb_adr_i > 8'h10 |=> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_force_rd; tk && !wb_we_i && wb_adr_i == 8'h00 |=> !wb_dat_o[5]; endproperty
  a_force_rd: assert property (p_force_rd) else $error("force reads one");
  property p_port_rd;
    tk && !wb_we_i && wb_adr_i == 8'h10 |=> wb_dat_o[1:0] == {dir_r, pv_r};
  endproperty
  a_port_rd: assert property (p_port_rd) else $error("port readback");
  property p_oe_dir; pin_oe == $past(dir_r); endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin enable");
  property p_pin_port; $past(com_r) == 2'h0 |-> pin_out == $past(pv_r); endproperty
  a_pin_port: assert property (p_pin_port) else $error("pin source");
endmodule
bind timer8_waveform_output timer8_wave_chk #(.TICK_DIV(TICK_DIV)) timer8_wave_chk_inst (
  .mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire
